//--- pkg/sslc_pkg.sv
// Shared constants of the serial switch-configuration link.
// Assumes a 250 MHz system clock on the controller end and a 16-switch device stage.
package sslc_pkg;

  localparam int SSLC_NUM_SW       = 16;
  localparam int SSLC_CHAIN_LEN    = 1;

  localparam int SSLC_CLK_SYS_KHZ  = 250000;
  localparam int SSLC_SCLK_MAX_KHZ = 66000;
  localparam int SSLC_LOAD_LOW_NS  = 16;
  localparam int SSLC_CLK_SYS_PS   = 4000;

  // Least half period of the serial clock, rounded up so the clock never exceeds its ceiling.
  localparam int SSLC_SCLK_HALF_CYC =
    (SSLC_CLK_SYS_KHZ + 2 * SSLC_SCLK_MAX_KHZ - 1) / (2 * SSLC_SCLK_MAX_KHZ);
  localparam int SSLC_LOAD_LOW_CYC =
    (SSLC_LOAD_LOW_NS * 1000 + SSLC_CLK_SYS_PS - 1) / SSLC_CLK_SYS_PS;

  localparam int SSLC_CNT_W = 8;

  localparam logic       SSLC_LOAD_N_IDLE = 1'h1;
  localparam logic       SSLC_SCLK_IDLE   = 1'h0;
  localparam logic       SSLC_CLEAR_RST   = 1'h0;
  localparam logic       SSLC_SHIFT_RST   = 1'h0;

  typedef enum {
    SSLC_IDLE,
    SSLC_SHIFT_LO,
    SSLC_SHIFT_HI,
    SSLC_STROBE
  } sslc_state_t;

endpackage

//--- pkg/sslc_if.sv
// Serial configuration link between a controller and a chain of switch devices.
// Assumes the bench or a wrapper joins the controller end and the device end through it.
`timescale 1ns/1ps
interface sslc_if;

  logic sclk;
  logic sdata;
  logic latch_load_n;
  logic latch_clear;
  logic sdout;

  modport ctrl (
    output sclk,
    output sdata,
    output latch_load_n,
    output latch_clear,
    input  sdout
  );

  modport dev (
    input  sclk,
    input  sdata,
    input  latch_load_n,
    input  latch_clear,
    output sdout
  );

endinterface

//--- rtl/sslc_switch.sv
// Device end: 16-stage shift register, latch bank and serial data output.
// Assumes the serial clock comes from the controller and may stand still between frames.
`timescale 1ns/1ps

// Summary of operation
// - Shift data in on each serial clock rise.
// - Highest switch bit first, switch zero last.
// - Controller keeps load strobe high while shifting.
// - Load strobe fall copies register into latches.
// - Strobe high: latches hold, shifting leaves them.
// - Controller shifts all, then strobes once.
// - Clear high forces all latches low.
// - Clear never touches the shift register.
// - Serial clock stays at or below 66 MHz.
// - One latch per switch, each independent.
// - Serial output feeds next device input.
// - Chain of N needs N*16 bits.
// - One strobe pulse updates every chained device.
// - Last output may be read back.
// - Serial output shows final register stage.
// - Strobe fall passes register to switches; low holds it.
// - Clear overrides the load strobe at the latches.
module sslc_switch
  import sslc_pkg::*;
#(
  parameter int NUM_SW = SSLC_NUM_SW
) (
  input  wire logic              rst_in,
  sslc_if.dev                    link,
  output logic [NUM_SW-1:0]      switch_on_out
);

  logic [NUM_SW-1:0] shift_r;
  logic [NUM_SW-1:0] shift_nxt;
  logic [NUM_SW-1:0] latch_r;
  logic [NUM_SW-1:0] latch_nxt;

  // The first bit in ends up in the top stage after all bits are shifted.
  always_comb begin
    shift_nxt = {shift_r[NUM_SW-2:0], link.sdata};
    latch_nxt = shift_r;
  end

  // Power-up reset is asynchronous because the serial clock may never run before it is needed.
  always_ff @(posedge link.sclk or posedge rst_in) begin
    if (rst_in) begin
      shift_r <= {NUM_SW{SSLC_SHIFT_RST}};
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // The latch bank is captured on the strobe's falling edge and then held until the next one or until a clear rise zeroes it.
  // Shifting while the strobe stays low is not passed through; the controller never does it.
  always_ff @(negedge link.latch_load_n or posedge link.latch_clear) begin
    if (link.latch_clear) begin
      latch_r <= {NUM_SW{SSLC_CLEAR_RST}};
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign link.sdout    = shift_r[NUM_SW-1];
  assign switch_on_out = latch_r;

endmodule // sslc_switch

//--- rtl/sslc_ctrl.sv
// Controller end: serialises a chain word, strobes the latches and reads back the old chain.
// Assumes a 250 MHz system clock; the serial clock is derived here and driven out.
`timescale 1ns/1ps
module sslc_ctrl
  import sslc_pkg::*;
#(
  parameter int CHAIN_LEN = SSLC_CHAIN_LEN,
  parameter int TOTAL     = CHAIN_LEN * SSLC_NUM_SW
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  input  wire logic             cmd_valid_in,
  input  wire logic [TOTAL-1:0] cmd_data_in,
  input  wire logic             clear_req_in,
  output logic                  cmd_ready_out,
  output logic                  done_out,
  output logic [TOTAL-1:0]      readback_out,
  sslc_if.ctrl                  link
);

  localparam logic [SSLC_CNT_W-1:0] HALF_LAST = SSLC_CNT_W'(SSLC_SCLK_HALF_CYC - 1);
  localparam logic [SSLC_CNT_W-1:0] LOAD_LAST = SSLC_CNT_W'(SSLC_LOAD_LOW_CYC - 1);
  localparam int                    BIT_W     = $clog2(TOTAL + 1);
  localparam logic [BIT_W-1:0]      BIT_LAST  = BIT_W'(TOTAL - 1);

  sslc_state_t             state_r,  state_nxt;
  logic [SSLC_CNT_W-1:0]   cnt_r,    cnt_nxt;
  logic [BIT_W-1:0]        bit_r,    bit_nxt;
  logic [TOTAL-1:0]        buf_r,    buf_nxt;
  logic [TOTAL-1:0]        rb_r,     rb_nxt;
  logic [TOTAL-1:0]        rbo_r,    rbo_nxt;
  logic                    sclk_r,   sclk_nxt;
  logic                    sdata_r,  sdata_nxt;
  logic                    load_n_r, load_n_nxt;
  logic                    clear_r,  clear_nxt;
  logic                    ready_r,  ready_nxt;
  logic                    done_r,   done_nxt;
  logic                    sdout_meta_r;
  logic                    sdout_sync_r;

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    bit_nxt    = bit_r;
    buf_nxt    = buf_r;
    rb_nxt     = rb_r;
    rbo_nxt    = rbo_r;
    sclk_nxt   = sclk_r;
    sdata_nxt  = sdata_r;
    load_n_nxt = load_n_r;
    ready_nxt  = ready_r;
    done_nxt   = 1'h0;
    clear_nxt  = clear_req_in;
    case (state_r)
      SSLC_IDLE: begin
        // A clear request blocks new frames from starting; a clear raised mid-frame still overlaps shifting.
        ready_nxt = !clear_req_in && !clear_r;
        if (cmd_valid_in && ready_r && !clear_req_in) begin
          buf_nxt   = cmd_data_in;
          sdata_nxt = cmd_data_in[TOTAL-1];
          bit_nxt   = BIT_LAST;
          cnt_nxt   = '0;
          ready_nxt = 1'h0;
          state_nxt = SSLC_SHIFT_LO;
        end
      end
      SSLC_SHIFT_LO: begin
        if (cnt_r == HALF_LAST) begin
          cnt_nxt   = '0;
          sclk_nxt  = 1'h1;
          rb_nxt    = {rb_r[TOTAL-2:0], sdout_sync_r};
          state_nxt = SSLC_SHIFT_HI;
        end else begin
          cnt_nxt = cnt_r + 1'h1;
        end
      end
      SSLC_SHIFT_HI: begin
        if (cnt_r == HALF_LAST) begin
          cnt_nxt  = '0;
          sclk_nxt = 1'h0;
          if (bit_r == '0) begin
            load_n_nxt = 1'h0;
            state_nxt  = SSLC_STROBE;
          end else begin
            bit_nxt   = bit_r - 1'h1;
            buf_nxt   = {buf_r[TOTAL-2:0], 1'h0};
            sdata_nxt = buf_r[TOTAL-2];
            state_nxt = SSLC_SHIFT_LO;
          end
        end else begin
          cnt_nxt = cnt_r + 1'h1;
        end
      end
      SSLC_STROBE: begin
        if (cnt_r == LOAD_LAST) begin
          cnt_nxt    = '0;
          load_n_nxt = 1'h1;
          rbo_nxt    = rb_r;
          done_nxt   = 1'h1;
          state_nxt  = SSLC_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'h1;
        end
      end
      default: begin
        state_nxt  = SSLC_IDLE;
        load_n_nxt = SSLC_LOAD_N_IDLE;
        sclk_nxt   = SSLC_SCLK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r      <= SSLC_IDLE;
      cnt_r        <= '0;
      bit_r        <= '0;
      buf_r        <= '0;
      rb_r         <= '0;
      rbo_r        <= '0;
      sclk_r       <= SSLC_SCLK_IDLE;
      sdata_r      <= 1'h0;
      load_n_r     <= SSLC_LOAD_N_IDLE;
      clear_r      <= 1'h0;
      ready_r      <= 1'h0;
      done_r       <= 1'h0;
      sdout_meta_r <= 1'h0;
      sdout_sync_r <= 1'h0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      bit_r        <= bit_nxt;
      buf_r        <= buf_nxt;
      rb_r         <= rb_nxt;
      rbo_r        <= rbo_nxt;
      sclk_r       <= sclk_nxt;
      sdata_r      <= sdata_nxt;
      load_n_r     <= load_n_nxt;
      clear_r      <= clear_nxt;
      ready_r      <= ready_nxt;
      done_r       <= done_nxt;
      sdout_meta_r <= link.sdout;
      sdout_sync_r <= sdout_meta_r;
    end
  end

  assign link.sclk         = sclk_r;
  assign link.sdata        = sdata_r;
  assign link.latch_load_n = load_n_r;
  assign link.latch_clear  = clear_r;
  assign cmd_ready_out     = ready_r;
  assign done_out          = done_r;
  assign readback_out      = rbo_r;

endmodule // sslc_ctrl

//--- bench/sslc_checker.sv
// Link checker: watches the wires between controller and device end.
// Assumes the controller's link outputs are registered on its system clock; sdout is registered on the serial clock.
`timescale 1ns/1ps
module sslc_checker
  import sslc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        latch_load_n,
  input  wire logic        latch_clear,
  input  wire logic        sdout,
  input  wire logic [15:0] switch_on_out
);
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic        sclk_r;
  logic        seen_r;
  logic        seen_nxt;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Shadow register runs on the link clock, so clear can never disturb it.
  always_comb sh_nxt = {sh_r[14:0], sdata};
  always_ff @(posedge sclk or posedge rst_in) begin
    if (rst_in) sh_r <= 16'h0000;
    else sh_r <= sh_nxt;
  end
  // Latches are unknown until a first clear, so the hold check waits for one.
  always_comb begin
    cnt_nxt  = latch_load_n ? cnt_r + 8'(sclk & ~sclk_r) : 8'h00;
    seen_nxt = seen_r | latch_clear;
  end
  always_ff @(posedge clk_sys_in) begin
    sclk_r <= rst_in ? 1'b0 : sclk;
    cnt_r  <= rst_in ? 8'h00 : cnt_nxt;
    seen_r <= rst_in ? 1'b0 : seen_nxt;
  end
  sequence load_low_s;
    !latch_load_n [*4];
  endsequence
  sequence sclk_high_s;
    sclk [*2] ##1 !sclk;
  endsequence
  chk_sdout_stage:
    assert property (sdout == sh_r[15]) else $error("Serial out is not the last stage.");
  chk_clear_off:
    assert property (latch_clear && $past(latch_clear) |-> switch_on_out == 16'h0000)
      else $error("Switches on during clear.");
  chk_load_copy:
    assert property ($fell(latch_load_n) && !latch_clear |=> latch_clear || switch_on_out == sh_r)
      else $error("Strobe did not copy the register.");
  chk_latch_hold:
    assert property (seen_r && latch_load_n && $past(latch_load_n) && !latch_clear
      && !$past(latch_clear) |-> $stable(switch_on_out)) else $error("Latches moved.");
  chk_no_shift_load:
    assert property (!latch_load_n |-> !sclk) else $error("Shift clock during strobe.");
  chk_strobe_width:
    assert property ($fell(latch_load_n) |-> load_low_s ##1 latch_load_n)
      else $error("Strobe pulse width wrong.");
  chk_sclk_rate:
    assert property ($rose(sclk) |-> sclk_high_s) else $error("Shift clock too fast.");
  chk_frame_bits:
    assert property ($fell(latch_load_n) |-> cnt_r == 8'h10) else $error("Bit count wrong.");
endmodule // sslc_checker

//--- bench/sslc_bench.sv
// Bench joining controller and device ends through the link interface.
// Assumes a single device in the chain and the controller's own clock divider.
`timescale 1ns/1ps
module sslc_bench
  import sslc_pkg::*;
;
  logic        clk_sys_in;
  logic        rst_in;
  logic        cmd_valid_in;
  logic        clear_req_in;
  logic        cmd_ready_out;
  logic        done_out;
  logic [15:0] cmd_data_in;
  logic [15:0] readback_out;
  logic [15:0] switch_on_out;
  logic [15:0] prev;
  logic [15:0] exp_sw;
  logic [15:0] words [6] = '{16'hA5C3, 16'h8000, 16'h0001, 16'h5A3C, 16'hFFFF, 16'h0000};
  int          mismatches;
  int          compares;
  // One frame: a low and a high half period per bit, then the strobe's low time.
  localparam int FRAME_CYC = 2 * SSLC_SCLK_HALF_CYC * SSLC_NUM_SW + SSLC_LOAD_LOW_CYC;
  sslc_if lnk();
  sslc_ctrl sslc_ctrl_i (.clk_sys_in, .rst_in, .cmd_valid_in, .cmd_data_in, .clear_req_in,
    .cmd_ready_out, .done_out, .readback_out, .link(lnk.ctrl));
  sslc_switch sslc_switch_i (.rst_in, .link(lnk.dev), .switch_on_out);
  sslc_checker sslc_checker_i (.clk_sys_in, .rst_in, .sclk(lnk.sclk), .sdata(lnk.sdata),
    .latch_load_n(lnk.latch_load_n), .latch_clear(lnk.latch_clear), .sdout(lnk.sdout),
    .switch_on_out);
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Clear may be held across a whole frame, so its strobe must be ignored.
  task automatic send(input logic [15:0] w, input logic clr);
    int n;
    cmd_data_in  = w;
    cmd_valid_in = 1'b1;
    while (cmd_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    cmd_valid_in = 1'b0;
    clear_req_in = clr;
    n = 0;
    while (done_out !== 1'b1 && n < 200) begin
      @(negedge clk_sys_in);
      n++;
      if (n == 40) begin
        chk(switch_on_out, clr ? 16'h0000 : exp_sw, "mid frame");
        chk(16'(lnk.latch_load_n), 16'h0001, "strobe high");
      end
    end
    chk(16'(n), 16'(FRAME_CYC), "frame length");
    chk(switch_on_out, clr ? 16'h0000 : w, "switches");
    chk(readback_out, prev, "readback");
    clear_req_in = 1'b0;
    prev = w;
    exp_sw = clr ? 16'h0000 : w;
  endtask
  initial begin
    rst_in       = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_data_in  = 16'h0000;
    clear_req_in = 1'b1;
    prev         = 16'h0000;
    exp_sw       = 16'h0000;
    repeat (16) @(negedge clk_sys_in);
    rst_in       = 1'b0;
    cmd_valid_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    chk(switch_on_out, 16'h0000, "cleared");
    chk(16'(cmd_ready_out), 16'h0000, "refused");
    chk({14'h0000, lnk.sclk, lnk.latch_load_n}, 16'h0001, "idle link");
    clear_req_in = 1'b0;
    foreach (words[i]) send(words[i], i == 3);
    end_of_test();
  end
  // Six frames take about two microseconds; ten times that marks a hang.
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule // sslc_bench
